/* File: design/lfp_top.sv */
// Panel refresh engine: APB registers, display memory, byte FIFO, timing and unpacking.
`timescale 1ns/1ps
`include "lfp_cfg.svh"

// ----------------------------------------
// Byte FIFO between memory fetch and pixel unpack
// ----------------------------------------
module lfp_fifo #(
	parameter int W = 8,
	parameter int D = 4
) (
	// Clock and reset.
	input wire logic clk,
	input wire logic rst_n,
	input wire logic flush,
	// Fill side.
	input wire logic in_valid,
	input wire logic [W-1:0] in_data,
	output logic in_ready,
	// Drain side.
	output logic out_valid,
	output logic [W-1:0] out_data,
	input wire logic out_ready
);
	localparam int AW = (D > 1) ? $clog2(D) : 1;
	logic [W-1:0] mem [D];
	logic [AW-1:0] wp_r, wp_nxt, rp_r, rp_nxt;
	logic [AW:0] cnt_r, cnt_nxt;
	logic push, pop;

	// Pointer and count update; flush empties the FIFO at once.
	always_comb
	begin
		push = in_valid && in_ready;
		pop = out_valid && out_ready;
		wp_nxt = wp_r;
		rp_nxt = rp_r;
		cnt_nxt = cnt_r;
		if (push)
			wp_nxt = (wp_r == AW'(D - 1)) ? '0 : wp_r + 1'b1;
		if (pop)
			rp_nxt = (rp_r == AW'(D - 1)) ? '0 : rp_r + 1'b1;
		if (push && !pop)
			cnt_nxt = cnt_r + 1'b1;
		else if (pop && !push)
			cnt_nxt = cnt_r - 1'b1;
		if (flush)
		begin
			wp_nxt = '0;
			rp_nxt = '0;
			cnt_nxt = '0;
		end
	end

	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			wp_r <= '0;
			rp_r <= '0;
			cnt_r <= '0;
		end
		else
		begin
			wp_r <= wp_nxt;
			rp_r <= rp_nxt;
			cnt_r <= cnt_nxt;
		end
	end

	// Storage has no reset; it is never read while empty.
	always_ff @(posedge clk)
	begin
		if (push)
			mem[wp_r] <= in_data;
	end

	assign in_ready = !flush && (cnt_r != (AW+1)'(D));
	assign out_valid = !flush && (cnt_r != '0);
	assign out_data = mem[rp_r];
endmodule

// ----------------------------------------
// Refresh engine top
// ----------------------------------------
// How it works
// R01 - Single or TFT frame lasts (display plus blank pixels) times (display plus blank lines) ticks.
// R02 - Dual frame lasts 2 times (line pixels) times (half display lines plus blank lines) ticks.
// R03 - Pixel tick is the input clock divided by one, two, four or eight.
// R04 - Vertical blank is a six-bit line count, zero to sixty-three.
// R05 - System should allow vertical blank of 7 lines, horizontal of 20 characters.
// R06 - Four packed depths: 1, 2, 4, 8 bits per pixel.
// R07 - One bit: eight pixels per byte, leftmost from bit 7, entries 0-1.
// R08 - Two bits: four pixels per byte, leftmost from bits 7:6, entries 0-3.
// R09 - Four bits: upper nibble left, lower nibble right, first sixteen entries.
// R10 - Eight bits: one pixel per byte, whole byte indexes the table.
// R11 - Colour panel: entry gives 4-bit red, green and blue.
// R12 - Monochrome panel: only the green part sets the grey level.
// R13 - Eight bits per pixel is refused while a monochrome panel is set.
// R14 - Horizontal blank pixels equal (field plus 4) times 8.
// R15 - Vertical blank lines equal the field value directly.
// R16 - Display width equals (size field plus 1) times 8.
// R17 - Display height equals the ten-bit size field plus 1.
// R18 - Horizontal and vertical counters on pixel ticks mark display and blank.
// R19 - Next byte is taken only after all its pixels went out, high first.
module lfp_top #(
	parameter int MEM_BYTES = 81920,
	parameter int FIFO_DEPTH = 4
) (
	// Clock and reset.
	input wire logic pclk,
	input wire logic presetn,
	// APB slave.
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// Panel side.
	output logic pix_tick,
	output logic pix_de,
	output lfp_pkg::lfp_rgb_s pix_rgb,
	output logic line_start,
	output logic frame_start
);
	localparam int MAW = $clog2(MEM_BYTES);
	logic [7:0] dmem [MEM_BYTES];
	logic [11:0] lut [256];

	// Pixel index from the top bits of a byte at the given depth.
	function automatic logic [7:0] f_top(input logic [7:0] b, input logic [1:0] bpp);
		case (bpp)
			2'h0: f_top = {7'h00, b[7]};
			2'h1: f_top = {6'h00, b[7:6]};
			2'h2: f_top = {4'h0, b[7:4]};
			default: f_top = b;
		endcase
	endfunction

	// Byte after the leading pixel has been shifted out.
	function automatic logic [7:0] f_shift(input logic [7:0] b, input logic [1:0] bpp);
		case (bpp)
			2'h0: f_shift = {b[6:0], 1'b0};
			2'h1: f_shift = {b[5:0], 2'h0};
			2'h2: f_shift = {b[3:0], 4'h0};
			default: f_shift = 8'h00;
		endcase
	endfunction

	// ----------------------------------------
	// Registers and APB
	// ----------------------------------------
	lfp_pkg::lfp_ctrl_s ctrl_r, ctrl_nxt;
	logic [7:0] hsize_r, hsize_nxt, lut_idx_r, lut_idx_nxt;
	logic [9:0] vsize_r, vsize_nxt;
	logic [4:0] hblank_r, hblank_nxt;
	logic [5:0] vblank_r, vblank_nxt;
	logic [MAW-1:0] maddr_r, maddr_nxt;
	logic [31:0] prdata_nxt;
	logic pready_nxt, pslverr_nxt, wr_fire, mem_we, lut_we, urun_clr;
	logic hit;
	logic urun_r, urun_nxt, urun_set;
	logic [15:0] frame_cnt_r, frame_cnt_nxt;
	logic [10:0] v_r, v_nxt;
	logic disp;

	// One wait state: answer flops load in the first access cycle.
	always_comb
	begin
		pready_nxt = psel && penable && !pready;
		wr_fire = psel && penable && pready && pwrite;
		hit = 1'b1;
		prdata_nxt = 32'h0000_0000;
		case (paddr)
			`LFP_OFF_CTRL: prdata_nxt = {24'h000000, ctrl_r};
			`LFP_OFF_HSIZE: prdata_nxt = {24'h000000, hsize_r};
			`LFP_OFF_VSIZE: prdata_nxt = {22'h000000, vsize_r};
			`LFP_OFF_HBLANK: prdata_nxt = {27'h0000000, hblank_r};
			`LFP_OFF_VBLANK: prdata_nxt = {26'h0000000, vblank_r};
			`LFP_OFF_LUT_IDX: prdata_nxt = {24'h000000, lut_idx_r};
			`LFP_OFF_LUT_DATA: prdata_nxt = {20'h00000, lut[lut_idx_r]};
			`LFP_OFF_MEM_ADDR: prdata_nxt = 32'(maddr_r);
			`LFP_OFF_MEM_DATA: prdata_nxt = {24'h000000, dmem[maddr_r]};
			`LFP_OFF_STATUS: prdata_nxt = {frame_cnt_r, 3'h0, urun_r, disp, v_r};
			default: hit = 1'b0;
		endcase
		pslverr_nxt = pready_nxt && !hit;
		if (!pready_nxt || pwrite)
			prdata_nxt = 32'h0000_0000;
		ctrl_nxt = ctrl_r;
		hsize_nxt = hsize_r;
		vsize_nxt = vsize_r;
		hblank_nxt = hblank_r;
		vblank_nxt = vblank_r;
		lut_idx_nxt = lut_idx_r;
		maddr_nxt = maddr_r;
		mem_we = 1'b0;
		lut_we = 1'b0;
		urun_clr = 1'b0;
		if (wr_fire)
		begin
			case (paddr)
				`LFP_OFF_CTRL:
				begin
					ctrl_nxt = lfp_pkg::lfp_ctrl_s'(pwdata[7:0]);
					if (ctrl_nxt.mono && ctrl_nxt.bpp == `LFP_BPP_8)
						ctrl_nxt.bpp = `LFP_BPP_4; // see R13
				end
				`LFP_OFF_HSIZE: hsize_nxt = pwdata[7:0];
				`LFP_OFF_VSIZE: vsize_nxt = pwdata[9:0];
				`LFP_OFF_HBLANK: hblank_nxt = pwdata[4:0];
				`LFP_OFF_VBLANK: vblank_nxt = pwdata[5:0]; // see R04
				`LFP_OFF_LUT_IDX: lut_idx_nxt = pwdata[7:0];
				`LFP_OFF_LUT_DATA:
				begin
					lut_we = 1'b1;
					lut_idx_nxt = lut_idx_r + 8'h01;
				end
				`LFP_OFF_MEM_ADDR: maddr_nxt = pwdata[MAW-1:0];
				`LFP_OFF_MEM_DATA:
				begin
					mem_we = 1'b1;
					maddr_nxt = (maddr_r == MAW'(MEM_BYTES - 1)) ? '0 : maddr_r + 1'b1;
				end
				`LFP_OFF_STATUS: urun_clr = pwdata[`LFP_ST_UNDERRUN];
				default: ;
			endcase
		end
		// An underrun in the clearing cycle survives the clear.
		urun_nxt = urun_set || (urun_r && !urun_clr);
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			ctrl_r <= lfp_pkg::lfp_ctrl_s'(`LFP_RST_CTRL);
			hsize_r <= `LFP_RST_HSIZE;
			vsize_r <= `LFP_RST_VSIZE;
			hblank_r <= `LFP_RST_HBLANK;
			vblank_r <= `LFP_RST_VBLANK;
			lut_idx_r <= 8'h00;
			maddr_r <= '0;
			prdata <= 32'h0000_0000;
			pready <= 1'b0;
			pslverr <= 1'b0;
			urun_r <= 1'b0;
		end
		else
		begin
			ctrl_r <= ctrl_nxt;
			hsize_r <= hsize_nxt;
			vsize_r <= vsize_nxt;
			hblank_r <= hblank_nxt;
			vblank_r <= vblank_nxt;
			lut_idx_r <= lut_idx_nxt;
			maddr_r <= maddr_nxt;
			prdata <= prdata_nxt;
			pready <= pready_nxt;
			pslverr <= pslverr_nxt;
			urun_r <= urun_nxt;
		end
	end

	// Arrays are written by software only and carry no reset.
	always_ff @(posedge pclk)
	begin
		if (mem_we)
			dmem[maddr_r] <= pwdata[7:0];
		if (lut_we)
			lut[lut_idx_r] <= pwdata[11:0];
	end

	// ----------------------------------------
	// Pixel tick and frame timing
	// ----------------------------------------
	logic [2:0] div_r, div_nxt;
	logic [12:0] h_r, h_nxt, h_line, h_disp;
	logic [11:0] h_display_pixels, htot;
	logic [10:0] v_display_lines, v_lines, v_disp;
	logic tick, tick_r, ls_nxt, fs_nxt, flush;

	always_comb
	begin
		tick = ctrl_r.en && (div_r == ((3'h1 << ctrl_r.div) - 3'h1)); // see R03
		div_nxt = (tick || !ctrl_r.en) ? 3'h0 : div_r + 3'h1;
		h_display_pixels = {hsize_r + 9'h001, 3'h0}; // see R16
		htot = h_display_pixels + 12'({9'(hblank_r) + `LFP_HBLANK_ADD, 3'h0}); // see R14
		v_display_lines = 11'(vsize_r) + 11'h001; // see R17
		if (ctrl_r.panel == lfp_pkg::PNL_DUAL)
		begin
			h_line = {htot, 1'b0}; // see R02
			h_disp = {h_display_pixels, 1'b0};
			v_disp = v_display_lines >> 1;
		end
		else
		begin
			h_line = {1'b0, htot}; // see R01
			h_disp = {1'b0, h_display_pixels};
			v_disp = v_display_lines;
		end
		v_lines = v_disp + 11'(vblank_r); // see R15
		disp = ctrl_r.en && (h_r < h_disp) && (v_r < v_disp); // see R18
		h_nxt = h_r;
		v_nxt = v_r;
		frame_cnt_nxt = frame_cnt_r;
		if (!ctrl_r.en)
		begin
			h_nxt = '0;
			v_nxt = '0;
		end
		else if (tick)
		begin
			if (h_r >= h_line - 13'h0001)
			begin
				h_nxt = '0;
				if (v_r >= v_lines - 11'h001)
				begin
					v_nxt = '0;
					frame_cnt_nxt = frame_cnt_r + 16'h0001;
				end
				else
					v_nxt = v_r + 11'h001;
			end
			else
				h_nxt = h_r + 13'h0001;
		end
		ls_nxt = tick && (h_r == '0);
		fs_nxt = ls_nxt && (v_r == '0);
		// Restart the fetch at the end of the last visible run so the
		// blanking time refills the FIFO before the next frame.
		flush = !ctrl_r.en || (tick && h_r == h_disp && v_r == v_disp - 11'h001);
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			div_r <= 3'h0;
			h_r <= '0;
			v_r <= '0;
			frame_cnt_r <= 16'h0000;
			tick_r <= 1'b0;
			line_start <= 1'b0;
			frame_start <= 1'b0;
		end
		else
		begin
			div_r <= div_nxt;
			h_r <= h_nxt;
			v_r <= v_nxt;
			frame_cnt_r <= frame_cnt_nxt;
			tick_r <= tick;
			line_start <= ls_nxt;
			frame_start <= fs_nxt;
		end
	end
	assign pix_tick = tick_r;

	// ----------------------------------------
	// Memory fetch, FIFO and unpacking
	// ----------------------------------------
	logic [MAW-1:0] faddr_r, faddr_nxt;
	logic f_ready, f_valid, f_pop;
	logic [7:0] f_data, f_byte, sh_r, sh_nxt, idx;
	logic [2:0] rem_r, rem_nxt;
	logic de_nxt;
	lfp_pkg::lfp_rgb_s rgb_nxt, ent;

	lfp_fifo #(
		.W(8),
		.D(FIFO_DEPTH)
	) u_fifo (
		.clk(pclk),
		.rst_n(presetn),
		.flush(flush),
		.in_valid(ctrl_r.en),
		.in_data(dmem[faddr_r]),
		.in_ready(f_ready),
		.out_valid(f_valid),
		.out_data(f_data),
		.out_ready(f_pop)
	);

	// Bytes are consumed in address order; a byte is drained fully first.
	always_comb
	begin
		faddr_nxt = faddr_r;
		if (flush)
			faddr_nxt = '0;
		else if (ctrl_r.en && f_ready)
			faddr_nxt = (faddr_r == MAW'(MEM_BYTES - 1)) ? '0 : faddr_r + 1'b1;
		f_pop = tick && disp && (rem_r == 3'h0); // see R19
		urun_set = f_pop && !f_valid;
		// An empty FIFO replays the stale shift byte, never its unwritten storage.
		f_byte = f_valid ? f_data : sh_r;
		sh_nxt = sh_r;
		rem_nxt = rem_r;
		idx = f_top(sh_r, ctrl_r.bpp);
		if (flush)
			rem_nxt = 3'h0;
		else if (f_pop)
		begin
			idx = f_top(f_byte, ctrl_r.bpp); // see R06 R07 R08 R09 R10
			sh_nxt = f_shift(f_byte, ctrl_r.bpp);
			rem_nxt = (3'h1 << (2'h3 - ctrl_r.bpp)) - 3'h1;
		end
		else if (tick && disp)
		begin
			sh_nxt = f_shift(sh_r, ctrl_r.bpp); // see R19
			rem_nxt = rem_r - 3'h1;
		end
		ent = lfp_pkg::lfp_rgb_s'(lut[idx]); // see R11
		if (ctrl_r.mono)
			ent = '{r: ent.g, g: ent.g, b: ent.g}; // see R12
		de_nxt = tick ? disp : pix_de;
		rgb_nxt = pix_rgb;
		if (tick)
			rgb_nxt = disp ? ent : '0;
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			faddr_r <= '0;
			sh_r <= 8'h00;
			rem_r <= 3'h0;
			pix_de <= 1'b0;
			pix_rgb <= '0;
		end
		else
		begin
			faddr_r <= faddr_nxt;
			sh_r <= sh_nxt;
			rem_r <= rem_nxt;
			pix_de <= de_nxt;
			pix_rgb <= rgb_nxt;
		end
	end
endmodule

/* File: design/lfp_cfg.svh */
// Register offsets, field positions, reset values and counts of the refresh engine.
`ifndef LFP_CFG_SVH
`define LFP_CFG_SVH
`define LFP_OFF_CTRL 8'h00
`define LFP_OFF_HSIZE 8'h04
`define LFP_OFF_VSIZE 8'h08
`define LFP_OFF_HBLANK 8'h0c
`define LFP_OFF_VBLANK 8'h10
`define LFP_OFF_LUT_IDX 8'h14
`define LFP_OFF_LUT_DATA 8'h18
`define LFP_OFF_MEM_ADDR 8'h1c
`define LFP_OFF_MEM_DATA 8'h20
`define LFP_OFF_STATUS 8'h24
`define LFP_CTRL_EN 0
`define LFP_CTRL_PANEL_LO 1
`define LFP_CTRL_MONO 3
`define LFP_CTRL_BPP_LO 4
`define LFP_CTRL_DIV_LO 6
`define LFP_ST_DISP 11
`define LFP_ST_UNDERRUN 12
`define LFP_ST_FRAME_LO 16
`define LFP_RST_CTRL 8'h00
`define LFP_RST_HSIZE 8'h00
`define LFP_RST_VSIZE 10'h000
`define LFP_RST_HBLANK 5'h00
`define LFP_RST_VBLANK 6'h00
`define LFP_HBLANK_ADD 9'h004
`define LFP_BPP_8 2'h3
`define LFP_BPP_4 2'h2
`endif

/* File: design/lfp_pkg.sv */
// Types shared by the refresh engine.
package lfp_pkg;
	typedef enum logic [1:0] {PNL_SINGLE, PNL_DUAL, PNL_TFT} lfp_panel_e;
	typedef struct packed {
		logic [3:0] r;
		logic [3:0] g;
		logic [3:0] b;
	} lfp_rgb_s;
	typedef struct packed {
		logic [1:0] div;
		logic [1:0] bpp;
		logic mono;
		lfp_panel_e panel;
		logic en;
	} lfp_ctrl_s;
endpackage

/* File: tb/lfp_top_properties.sv */
// Port checker of the refresh engine, with its bind.
`timescale 1ns/1ps

// ----
// Checker
// ----
module lfp_top_checker (
	// Clock and reset.
	input wire logic pclk,
	input wire logic presetn,
	// APB.
	input wire logic psel,
	input wire logic penable,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr,
	// Pixels.
	input wire logic pix_tick,
	input wire logic pix_de,
	input wire lfp_pkg::lfp_rgb_s pix_rgb,
	input wire logic line_start,
	input wire logic frame_start
);
	// All checks use the bus clock and rest while reset is low.
	default clocking cb @(posedge pclk);
	endclocking
	default disable iff (!presetn);
	// One wait state; the answer stands for a single cycle.
	sequence s_acc; psel && penable && !pready; endsequence
	sequence s_ans; pready ##1 !pready; endsequence
	property p_wait; s_acc |=> s_ans; endproperty
	a_wait: assert property (p_wait) else $error("pready timing");
	property p_cause; pready |-> psel && penable && $past(psel && penable); endproperty
	a_cause: assert property (p_cause) else $error("pready without access");
	property p_err; pslverr |-> pready; endproperty
	a_err: assert property (p_err) else $error("stray pslverr");
	property p_rdz; !pready |-> prdata == 32'h0; endproperty
	a_rdz: assert property (p_rdz) else $error("stray prdata");
	// Pixel outputs move only on a tick, so the panel never sees a half pixel.
	property p_hold; !pix_tick |-> $stable(pix_de) && $stable(pix_rgb); endproperty
	a_hold: assert property (p_hold) else $error("pixel off tick");
	property p_dark; !pix_de |-> pix_rgb == 12'h000; endproperty
	a_dark: assert property (p_dark) else $error("blank not dark");
	property p_frm; frame_start |-> line_start && pix_tick && pix_de; endproperty
	a_frm: assert property (p_frm) else $error("frame pulse");
	property p_lin; line_start |-> pix_tick; endproperty
	a_lin: assert property (p_lin) else $error("line pulse");
endmodule

bind lfp_top lfp_top_checker chk (.pclk(pclk), .presetn(presetn), .psel(psel),
	.penable(penable), .prdata(prdata), .pready(pready), .pslverr(pslverr),
	.pix_tick(pix_tick), .pix_de(pix_de), .pix_rgb(pix_rgb), .line_start(line_start),
	.frame_start(frame_start));

/* File: tb/lfp_panel_model.sv */
// Panel model that measures frame and tick timing and keeps the first pixels.
`timescale 1ns/1ps

// ----
// Panel
// ----
module lfp_panel_model (
	// Clock and reset.
	input wire logic clk,
	input wire logic rst_n,
	// Pixel stream.
	input wire logic tick,
	input wire logic de,
	input wire logic frm,
	input wire logic lin,
	input wire lfp_pkg::lfp_rgb_s rgb
);
	int nfr, tcnt, flen, vcnt, vis, ccnt, gap, px, k, lcnt, nln;
	lfp_pkg::lfp_rgb_s cap [16];

	// Latches only on ticks, like a real panel; tick, visible, line and pixel counts restart at each frame pulse, the clock count at each tick.
	always @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
			{nfr, tcnt, flen, vcnt, vis, ccnt, gap, px, lcnt, nln} <= '0;
		else
		begin
			ccnt <= tick ? 1 : ccnt + 1;
			k = frm ? 0 : px;
			if (tick)
			begin
				gap <= ccnt;
				nfr <= nfr + int'(frm);
				tcnt <= frm ? 1 : tcnt + 1;
				vcnt <= (frm ? 0 : vcnt) + int'(de);
				flen <= frm ? tcnt : flen;
				vis <= frm ? vcnt : vis;
				lcnt <= (frm ? 0 : lcnt) + int'(lin);
				nln <= frm ? lcnt : nln;
				px <= k + int'(de && k < 16);
			end
			if (tick && de && k < 16)
				cap[k] <= rgb;
		end
	end
endmodule

/* File: tb/testbench.sv */
// Self-checking bench of the refresh engine.
`timescale 1ns/1ps
`include "lfp_cfg.svh"

// ----
// Bench
// ----
module testbench;
	localparam int HS = 0;
	localparam int HB = 1;
	localparam int VS = 3;
	localparam logic [7:0] CFG [6] = '{8'h01, 8'h53, 8'ha5, 8'hf5, 8'h39, 8'h19};
	logic pclk, presetn, psel, penable, pwrite, pready, pslverr, rerr;
	logic pix_tick, pix_de, line_start, frame_start;
	logic [7:0] paddr;
	logic [31:0] pwdata, prdata, rd;
	lfp_pkg::lfp_rgb_s pix_rgb;
	logic [11:0] lut [256];
	logic [7:0] mem [32];
	int err_count, n_checks, seed, vb;

	// A small memory keeps elaboration light; timing counts stay as programmed.
	lfp_top #(.MEM_BYTES(256), .FIFO_DEPTH(4)) dut (.pclk(pclk), .presetn(presetn),
		.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr), .pix_tick(pix_tick),
		.pix_de(pix_de), .pix_rgb(pix_rgb), .line_start(line_start),
		.frame_start(frame_start));
	lfp_panel_model pnl (.clk(pclk), .rst_n(presetn), .tick(pix_tick), .de(pix_de),
		.frm(frame_start), .lin(line_start), .rgb(pix_rgb));

	// Bus clock.
	initial
	begin
		pclk = 1'b0;
		forever #2 pclk = ~pclk;
	end

	// One comparison, reported at once on mismatch.
	task automatic chk(input string s, input logic [31:0] e, input logic [31:0] g);
		n_checks++;
		if (g !== e)
		begin
			err_count++;
			$display("FAIL %s expected %h seen %h", s, e, g);
		end
	endtask

	// One APB transfer; data and error are taken at the edge that sees pready.
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int i;
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		i = 0;
		do
			@(posedge pclk);
		while (pready !== 1'b1 && i++ < 50);
		chk("apb answer", 32'h1, 32'(i < 50));
		rd = prdata;
		rerr = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
	endtask

	// Settle for three frames, then let the first sixteen pixels arrive.
	task automatic settle();
		int f0, i;
		f0 = pnl.nfr;
		i = 0;
		while ((pnl.nfr < f0 + 3 || pnl.px < 16) && i++ < 40000)
			@(posedge pclk);
		chk("frame wait", 32'h1, 32'(i < 40000));
	endtask

	// Control as stored: eight bits on a mono panel falls back to four.
	function automatic logic [7:0] ectl(input logic [7:0] c);
		if (c[3] && c[5:4] == 2'h3)
			c[5:4] = 2'h2;
		return c;
	endfunction

	// Ticks in one frame.
	function automatic logic [31:0] elen(input logic [7:0] c);
		int h;
		h = 8 * (HS + 1) + 8 * (HB + 4);
		if (c[2:1] == 2'h1)
			return 32'(2 * h * ((VS + 1) / 2 + vb));
		return 32'(h * (VS + 1 + vb));
	endfunction

	// Line pulses in one frame.
	function automatic logic [31:0] elin(input logic [7:0] c);
		if (c[2:1] == 2'h1)
			return 32'((VS + 1) / 2 + vb);
		return 32'(VS + 1 + vb);
	endfunction

	// Colour of pixel k: high bits first, then through the table.
	function automatic logic [11:0] epix(input int k, input logic [7:0] c);
		int b, p;
		logic [7:0] v;
		logic [11:0] e;
		b = 1 << c[5:4];
		p = 8 / b;
		v = mem[k / p] >> (8 - b * (k % p + 1));
		e = lut[v & 8'((1 << b) - 1)];
		if (c[3])
			e = {e[7:4], e[7:4], e[7:4]};
		return e;
	endfunction

	// Verdict and end of run.
	task automatic report_and_stop();
		$display("checks %0d mismatches %0d", n_checks, err_count);
		if (err_count == 0 && n_checks > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask

	// Watchdog well past the longest expected run.
	initial
	begin
		repeat (100000) @(posedge pclk);
		err_count++;
		report_and_stop();
	end

	// Reset, register checks, table loads and one pass per panel setup.
	initial
	begin
		{psel, penable, pwrite, paddr, pwdata} = '0;
		presetn = 1'b0;
		seed = 32'h9583;
		err_count = 0;
		n_checks = 0;
		repeat (20) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		apb(1'b0, `LFP_OFF_CTRL, 32'h0);
		chk("ctrl reset", 32'h0, rd);
		apb(1'b1, 8'h28, 32'h1);
		chk("unmapped", 32'h1, 32'(rerr));
		apb(1'b1, `LFP_OFF_HSIZE, 32'(HS));
		apb(1'b1, `LFP_OFF_VSIZE, 32'(VS));
		apb(1'b1, `LFP_OFF_HBLANK, 32'(HB));
		apb(1'b1, `LFP_OFF_LUT_IDX, 32'h0);
		for (int i = 0; i < 256; i++)
		begin
			lut[i] = 12'($random(seed));
			apb(1'b1, `LFP_OFF_LUT_DATA, {20'h0, lut[i]});
		end
		apb(1'b1, `LFP_OFF_MEM_ADDR, 32'h0);
		for (int i = 0; i < 32; i++)
		begin
			mem[i] = 8'($random(seed));
			apb(1'b1, `LFP_OFF_MEM_DATA, {24'h0, mem[i]});
		end
		// Read back one table entry, one memory byte and the height field.
		apb(1'b1, `LFP_OFF_LUT_IDX, 32'h5);
		apb(1'b0, `LFP_OFF_LUT_DATA, 32'h0);
		chk("lut read", {20'h0, lut[5]}, rd);
		apb(1'b1, `LFP_OFF_MEM_ADDR, 32'h3);
		apb(1'b0, `LFP_OFF_MEM_DATA, 32'h0);
		chk("mem read", {24'h0, mem[3]}, rd);
		apb(1'b0, `LFP_OFF_VSIZE, 32'h0);
		chk("vsize", 32'(VS), rd);
		foreach (CFG[i])
		begin
			vb = (i == 0) ? 63 : $random(seed) & 7;
			apb(1'b1, `LFP_OFF_VBLANK, 32'(vb));
			apb(1'b1, `LFP_OFF_CTRL, {24'h0, CFG[i]});
			apb(1'b0, `LFP_OFF_CTRL, 32'h0);
			chk("ctrl", {24'h0, ectl(CFG[i])}, rd);
			settle();
			chk("frame", elen(CFG[i]), 32'(pnl.flen));
			chk("tick gap", 32'h1 << CFG[i][7:6], 32'(pnl.gap));
			chk("visible", 32'd32, 32'(pnl.vis));
			chk("lines", elin(CFG[i]), 32'(pnl.nln));
			for (int k = 0; k < 16; k++)
				chk("pixel", 32'(epix(k, ectl(CFG[i]))), 32'(pnl.cap[k]));
		end
		// A steady setup must keep the FIFO ahead of the pixels once the flag is cleared.
		apb(1'b1, `LFP_OFF_STATUS, 32'h1 << `LFP_ST_UNDERRUN);
		settle();
		apb(1'b0, `LFP_OFF_STATUS, 32'h0);
		chk("underrun", 32'h0, 32'(rd[`LFP_ST_UNDERRUN]));
		report_and_stop();
	end
endmodule
